// File: sram_wr_pkg.sv
/*
 * Constants of the write-port capture block; its array takes its widths as parameters only.
 * Assumes the includer picks one of the documented widths: 8, 9, 18 or 36 bits.
 */
package sram_wr_pkg;
	// Documented data widths
	localparam int DATA_W_X8 = 8;
	localparam int DATA_W_X36 = 36;
	// Lane sizes of the write masks
	localparam int NIBBLE_LANE_W = 4;
	localparam int BYTE_LANE_W = 9;
	localparam int NIBBLE_MASKS = 2;
	// Words carried by one write burst
	localparam int BURST_LEN = 2;
	// Default address width of the widest part
	localparam int ADDR_W_X36 = 19;
	// Entries of the buffer in front of the array
	localparam logic [1:0] BUF_ENTRIES = 2'h2;
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_ONE = 2'h1;
	// Pin synchroniser reset value
	localparam logic SYNC_RST_VAL = 1'b0;
	// Capture sequence states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_WAIT_KN
	} cap_state_t;
endpackage

// File: sram_wr_array.sv
/*
 * Bit-masked storage array, one location holding a whole two-word burst.
 * Assumes the writer supplies a per-bit enable; read data leave from a register.
 */
`timescale 1ns/10ps
module sram_wr_array #(
	parameter int ADDR_W = 19,
	parameter int WORD_W = 72
) (
	// Clock
	input wire logic i_clk,
	// Write side
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_waddr,
	input wire logic [WORD_W-1:0] i_wdata,
	input wire logic [WORD_W-1:0] i_wbit_en,
	// Read side
	input wire logic [ADDR_W-1:0] i_raddr,
	output logic [WORD_W-1:0] o_rdata
);
	logic [WORD_W-1:0] mem [0:(2**ADDR_W)-1];

	// Masked write keeps disabled lanes untouched
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= (mem[i_waddr] & ~i_wbit_en) | (i_wdata & i_wbit_en); // R7 R10
		end
	end

	// Registered read
	always_ff @(posedge i_clk) begin
		o_rdata <= mem[i_raddr];
	end
endmodule

// File: sram_write_port.sv
/*
 * Write-port capture of a double-data-rate two-word-burst SRAM: pin sampling,
 * port select, per-lane masks, a two-entry buffer and the storage array.
 * Assumes K and K# are slow against i_clk (each level lasts several i_clk cycles),
 * so their rising edges are found after two-flop synchronisers.
 */
// How it works
// R1: Data sampled on K rise and again on K# rise during a write.
// R2: Data width is 8, 9, 18 or 36 bits by parameter.
// R3: Write port select sampled low on K rise starts a write.
// R4: Select high on K rise deselects; data inputs are ignored.
// R5: Eight-bit part: nibble mask 0 gates bits 3..0, mask 1 bits 7..4.
// R6: Nibble masks sampled on the same edge as their data beat.
// R7: Nibble with mask high is not written; memory nibble unchanged.
// R8: Wider parts: byte mask i gates nine-bit lane i.
// R9: Byte masks sampled on the same edge as their data beat.
// R10: Byte lane with mask high is not written; memory byte unchanged.
// R11: Address sampled on K# rise is the write address.
// R12: Address ignored while the write port is deselected.
// R13: Each write puts two masked words into one location. The code drops a burst that meets a full buffer.
`timescale 1ns/10ps
module sram_write_port
	import sram_wr_pkg::*;
#(
	parameter int DATA_W = sram_wr_pkg::DATA_W_X36,
	parameter int ADDR_W = sram_wr_pkg::ADDR_W_X36
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Memory pins from the controller
	input wire logic i_k,
	input wire logic i_k_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic i_write_port_select_n,
	input wire logic [sram_wr_pkg::NIBBLE_MASKS-1:0] i_nibble_write_mask_n,
	input wire logic [3:0] i_byte_write_mask_n,
	// Array side
	input wire logic i_array_hold,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [2*DATA_W-1:0] o_rd_data,
	// Status
	output logic o_wr_ready,
	output logic o_write_done,
	output logic o_overrun
);
	import sram_wr_pkg::*;

	localparam bit NIB_CFG = (DATA_W == DATA_W_X8); // R2
	localparam int LANE_W = NIB_CFG ? NIBBLE_LANE_W : BYTE_LANE_W;
	localparam int MASK_W = NIB_CFG ? NIBBLE_MASKS : (DATA_W + BYTE_LANE_W - 1) / BYTE_LANE_W;
	localparam int PIN_W = 3 + ADDR_W + DATA_W + MASK_W;
	localparam int ENT_W = ADDR_W + BURST_LEN * (DATA_W + MASK_W);

	logic [MASK_W-1:0] mask_pin;
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic k_s;
	logic kn_s;
	logic wps_n_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic [MASK_W-1:0] mask_s;
	logic k_prev_q;
	logic kn_prev_q;
	logic k_rise;
	logic kn_rise;
	cap_state_t state_q;
	logic [DATA_W-1:0] beat0_q;
	logic [MASK_W-1:0] mask0_q;
	logic push_q;
	logic [ADDR_W-1:0] push_addr_q;
	logic [BURST_LEN*DATA_W-1:0] push_data_q;
	logic [BURST_LEN*MASK_W-1:0] push_mask_q;
	logic [ENT_W-1:0] buf_q [0:1];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] count_q;
	logic buf_in_ready;
	logic push_ok;
	logic pop;
	logic [ENT_W-1:0] head;
	logic [ADDR_W-1:0] pop_addr;
	logic [BURST_LEN*DATA_W-1:0] pop_data;
	logic [BURST_LEN*MASK_W-1:0] pop_mask;
	logic [BURST_LEN*DATA_W-1:0] pop_bit_en;

	// Mask pins in use for this width
	assign mask_pin = NIB_CFG ? MASK_W'(i_nibble_write_mask_n) : i_byte_write_mask_n[MASK_W-1:0]; // R5 R8

	// Every pin passes two flops before use
	// Select resets to the asserted level, but no K edge can pass before real pins do
	assign pins = {i_k, i_k_n, i_write_port_select_n, i_addr, i_data, mask_pin};
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sync1_q <= {PIN_W{SYNC_RST_VAL}};
			sync2_q <= {PIN_W{SYNC_RST_VAL}};
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end
	assign {k_s, kn_s, wps_n_s, addr_s, data_s, mask_s} = sync2_q;

	// Rising edges of both input clocks
	// Edge detectors reset low, the idle level of both clock pins
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			k_prev_q <= SYNC_RST_VAL;
			kn_prev_q <= SYNC_RST_VAL;
		end else begin
			k_prev_q <= k_s;
			kn_prev_q <= kn_s;
		end
	end
	assign k_rise = k_s & ~k_prev_q;
	assign kn_rise = kn_s & ~kn_prev_q;

	// Capture sequence: select on K, second beat and address on K#
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
		end else if (k_rise) begin
			state_q <= wps_n_s ? ST_IDLE : ST_WAIT_KN; // R3 R4
		end else if (kn_rise) begin
			state_q <= ST_IDLE;
		end
	end

	// First beat and its mask on K
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			beat0_q <= '0;
			mask0_q <= '1;
		end else if (k_rise && !wps_n_s) begin
			beat0_q <= data_s; // R1
			mask0_q <= mask_s; // R6 R9
		end
	end

	// Second beat, its mask and the write address on K#
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			push_q <= 1'b0;
			push_addr_q <= '0;
			push_data_q <= '0;
			push_mask_q <= '1;
		end else begin
			push_q <= kn_rise && (state_q == ST_WAIT_KN);
			if (kn_rise && state_q == ST_WAIT_KN) begin
				push_addr_q <= addr_s; // R11 R12
				push_data_q <= {data_s, beat0_q}; // R1 R13
				push_mask_q <= {mask_s, mask0_q}; // R6 R9
			end
		end
	end

	// Two-entry buffer in front of the array
	// A burst that meets a full buffer is dropped and flagged, never stalled
	assign buf_in_ready = (count_q != BUF_ENTRIES);
	assign push_ok = push_q & buf_in_ready;
	assign pop = (count_q != BUF_EMPTY) & ~i_array_hold;
	assign head = buf_q[rd_ptr_q];
	assign {pop_addr, pop_data, pop_mask} = head;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q <= BUF_EMPTY;
		end else begin
			if (push_ok) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			count_q <= count_q + {1'b0, push_ok} - {1'b0, pop};
		end
	end

	// Entry storage
	always_ff @(posedge i_clk) begin
		if (push_ok) begin
			buf_q[wr_ptr_q] <= {push_addr_q, push_data_q, push_mask_q}; // R13
		end
	end

	// Status flags
	// Ready follows the count as it will stand after this cycle
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wr_ready <= 1'b0;
			o_write_done <= 1'b0;
			o_overrun <= 1'b0;
		end else begin
			o_wr_ready <= (count_q + {1'b0, push_ok} - {1'b0, pop}) != BUF_ENTRIES;
			o_write_done <= pop;
			o_overrun <= push_q & ~buf_in_ready;
		end
	end

	// Each mask lane spreads over its data bits, active low
	for (genvar b = 0; b < BURST_LEN * DATA_W; b++) begin : g_lane
		assign pop_bit_en[b] = ~pop_mask[(b / DATA_W) * MASK_W + (b % DATA_W) / LANE_W]; // R5 R7 R8 R10
	end

	sram_wr_array #(
		.ADDR_W(ADDR_W),
		.WORD_W(BURST_LEN * DATA_W)
	) u_array (
		.i_clk(i_clk),
		.i_we(pop),
		.i_waddr(pop_addr),
		.i_wdata(pop_data),
		.i_wbit_en(pop_bit_en),
		.i_raddr(i_rd_addr),
		.o_rdata(o_rd_data)
	);

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence write_start_s;
		k_rise && !wps_n_s;
	endsequence
	sequence second_beat_s;
		kn_rise && state_q == ST_WAIT_KN;
	endsequence
	sequence desel_start_s;
		k_rise && wps_n_s;
	endsequence
	sequence stray_kn_s;
		kn_rise && state_q == ST_IDLE;
	endsequence

	select_deselect_a: assert property (k_rise && wps_n_s |=> state_q == ST_IDLE && !push_q) // R4
		else $error("deselected write port started a write");
	select_start_a: assert property (write_start_s |=> state_q == ST_WAIT_KN) // R3
		else $error("sampled low select did not start a write");
	beat0_capture_a: assert property (write_start_s |=> beat0_q == $past(data_s)) // R1
		else $error("first beat not captured on K rise");
	burst_push_a: assert property (write_start_s ##[1:300] second_beat_s |=> push_q) // R13
		else $error("two-beat burst not pushed");
	addr_capture_a: assert property (second_beat_s |=> push_addr_q == $past(addr_s)) // R11
		else $error("write address not taken on K# rise");
	addr_ignored_a: assert property (!push_q |-> $stable(push_addr_q)) // R12
		else $error("address changed while port deselected");
	lane_mask_a: assert property (pop |-> pop_bit_en[LANE_W-1:0] == {LANE_W{~pop_mask[0]}}) // R7 R10
		else $error("lane enable does not follow its mask");
	beat1_mask_a: assert property (second_beat_s |=> push_mask_q[2*MASK_W-1:MASK_W] == $past(mask_s)) // R6 R9
		else $error("second beat mask not taken with its data");
	write_done_a: assert property (pop |=> o_write_done) else $error("array write not reported");
	overrun_flag_a: assert property (push_q && count_q == BUF_ENTRIES |=> o_overrun)
		else $error("full buffer dropped a burst silently");

	// Capture path: what a deselected or stray clock edge must leave alone
	desel_hold_a: assert property ( // R4
		desel_start_s |=> $stable(beat0_q))
		else $error("deselected write overwrote the first beat");
	kn_alone_a: assert property ( // R4 R12
		stray_kn_s |=> !push_q)
		else $error("K# rise without a started write pushed a burst");
	beat0_keep_a: assert property ( // R13
		state_q == ST_WAIT_KN && !k_rise |=> $stable(beat0_q))
		else $error("first beat changed while waiting for K#");
	state_idle_a: assert property ( // R13
		kn_rise && !k_rise |=> state_q == ST_IDLE)
		else $error("burst did not end on K# rise");

	// Capture path: both beats and both masks travel together
	beat0_mask_a: assert property ( // R6 R9
		write_start_s |=> mask0_q == $past(mask_s))
		else $error("first beat mask not taken with its data");
	burst_pair_a: assert property ( // R1 R13
		second_beat_s |=> push_data_q == {$past(data_s), $past(beat0_q)})
		else $error("burst words not paired in order");
	push_pulse_a: assert property ( // R13
		push_q |=> !push_q)
		else $error("one burst pushed twice");
	lane_top_a: assert property ( // R5 R8
		pop |-> pop_bit_en[BURST_LEN*DATA_W-1] == ~pop_mask[BURST_LEN*MASK_W-1])
		else $error("top lane enable does not follow the last mask");

	// Buffer: occupancy, ready level and the status pulses
	buf_bound_a: assert property (
		count_q <= BUF_ENTRIES)
		else $error("buffer count out of range");
	ready_room_a: assert property (
		o_wr_ready |-> count_q != BUF_ENTRIES)
		else $error("ready shown while the buffer is full");
	hold_keep_a: assert property (
		i_array_hold && !push_ok |=> $stable(count_q))
		else $error("held buffer drained into the array");
	overrun_full_a: assert property (
		o_overrun |-> $past(count_q) == BUF_ENTRIES)
		else $error("overrun reported with room in the buffer");
	done_single_a: assert property (
		o_write_done |-> $past(pop))
		else $error("write reported without an array write");
endmodule

// File: sram_ctrl_model.sv
/* Controller model driving clock pins, address, data, select and byte masks.
   Assumes i_clk is the bench clock; pins change on its falling edge. */
`timescale 1ns/10ps
module sram_ctrl_model #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 4
) (
	// Bench clock
	input wire logic i_clk,
	// Memory pins
	output logic o_k,
	output logic o_k_n,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_data,
	output logic o_sel_n,
	output logic [3:0] o_bmask_n
);
	// Idle pins: clocks stand still, port off
	initial begin
		{o_k, o_k_n, o_sel_n} = 3'h1;
		o_addr = '0;
		o_data = '0;
		o_bmask_n = 4'hf;
	end
	// Each level lasts four bench cycles
	task automatic hold_pins();
		repeat (4) @(negedge i_clk);
	endtask
	// One burst: beat 0 at K rise, beat 1 and address at K# rise
	task automatic burst(input logic sel_n, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d0, d1, input logic [3:0] m0, m1);
		o_sel_n = sel_n;
		o_data = d0;
		o_bmask_n = m0;
		o_addr = ~a;
		hold_pins();
		o_k = 1'b1;
		hold_pins();
		o_k = 1'b0;
		o_data = d1;
		o_bmask_n = m1;
		o_addr = a;
		hold_pins();
		o_k_n = 1'b1;
		hold_pins();
		o_k_n = 1'b0;
		// Released pins carry junk, not the last value
		o_sel_n = 1'b1;
		o_data = ~d1;
		o_addr = ~a;
		o_bmask_n = ~m1;
		// Let an edge pass so a following burst never drives a pin twice at once
		@(negedge i_clk);
	endtask
endmodule

// File: sram_write_port_test.sv
/* Self-checking bench of the write port, 36-bit and 8-bit parts, each driven by a model.
   Assumes the array can be read while the buffer is held. */
`timescale 1ns/10ps
module sram_write_port_test;
	import sram_wr_pkg::*;
	localparam int DW = 36;
	localparam int AW = 4;
	localparam logic [DW-1:0] D0 = 36'h123456789;
	localparam logic [DW-1:0] D1 = 36'hfedcba987;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_array_hold = 1'b0;
	logic [AW-1:0] i_rd_addr = '0;
	logic k, k_n, sel_n, o_wr_ready, o_write_done, o_overrun;
	logic [AW-1:0] addr;
	logic [DW-1:0] data;
	logic [3:0] bmask_n;
	logic [2*DW-1:0] o_rd_data, q;
	// Second block in the eight-bit nibble-mask configuration
	localparam int DW8 = 8;
	logic k8, k8_n, sel8_n, done8;
	logic [AW-1:0] addr8;
	logic [DW8-1:0] data8;
	logic [3:0] mask8_n;
	logic [2*DW8-1:0] rd_data8, q8;
	int n_done8 = 0;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_done = 0;
	int n_over = 0;
	// Clock
	always #2.5 i_clk = ~i_clk;
	sram_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) u_sram_ctrl_model (.i_clk(i_clk), .o_k(k),
		.o_k_n(k_n), .o_addr(addr), .o_data(data), .o_sel_n(sel_n), .o_bmask_n(bmask_n));
	sram_write_port #(.DATA_W(DW), .ADDR_W(AW)) u_sram_write_port (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_k(k), .i_k_n(k_n), .i_addr(addr), .i_data(data),
		.i_write_port_select_n(sel_n), .i_nibble_write_mask_n(2'h3),
		.i_byte_write_mask_n(bmask_n), .i_array_hold(i_array_hold), .i_rd_addr(i_rd_addr),
		.o_rd_data(o_rd_data), .o_wr_ready(o_wr_ready), .o_write_done(o_write_done),
		.o_overrun(o_overrun));
	sram_ctrl_model #(.DATA_W(DW8), .ADDR_W(AW)) u_sram_ctrl_model_x8 (.i_clk(i_clk),
		.o_k(k8), .o_k_n(k8_n), .o_addr(addr8), .o_data(data8), .o_sel_n(sel8_n),
		.o_bmask_n(mask8_n));
	sram_write_port #(.DATA_W(DW8), .ADDR_W(AW)) u_sram_write_port_x8 (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_k(k8), .i_k_n(k8_n), .i_addr(addr8), .i_data(data8),
		.i_write_port_select_n(sel8_n), .i_nibble_write_mask_n(mask8_n[1:0]),
		.i_byte_write_mask_n(mask8_n), .i_array_hold(i_array_hold), .i_rd_addr(i_rd_addr),
		.o_rd_data(rd_data8), .o_wr_ready(), .o_write_done(done8), .o_overrun());
	// Count status pulses where they are settled
	always @(negedge i_clk) begin
		if (o_write_done === 1'b1) n_done++;
		if (o_overrun === 1'b1) n_over++;
		if (done8 === 1'b1) n_done8++;
	end
	task automatic results();
		if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic bad(input string msg);
		n_mismatch++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask
	task automatic chk_word(input logic [2*DW-1:0] got, exp);
		n_tests++;
		if (got !== exp) bad("stored burst");
	endtask
	task automatic chk_bit(input logic got, exp);
		n_tests++;
		if (got !== exp) bad("ready flag");
	endtask
	task automatic chk_cnt(input int got, exp);
		n_tests++;
		if (got != exp) bad("status pulse count");
	endtask
	// Keep lanes whose mask is high
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, nw, input logic [3:0] m);
		merge = old;
		for (int l = 0; l < 4; l++) if (!m[l]) merge[l*9 +: 9] = nw[l*9 +: 9];
	endfunction
	task automatic rd(input logic [AW-1:0] a);
		@(negedge i_clk) i_rd_addr = a;
		@(negedge i_clk) q = o_rd_data;
		q8 = rd_data8;
	endtask
	task automatic wait_done(input int n);
		for (int i = 0; i < 40 && n_done < n; i++) @(negedge i_clk);
		if (n_done < n) begin
			bad("write never completed");
			results();
		end
	endtask
	task automatic t_full();
		chk_bit(o_wr_ready, 1'b1);
		u_sram_ctrl_model.burst(1'b0, 4'h5, D0, D1, 4'h0, 4'h0);
		wait_done(1);
		rd(4'h5);
		chk_word(q, {D1, D0});
	endtask
	task automatic t_desel();
		u_sram_ctrl_model.burst(1'b1, 4'h5, ~D0, ~D1, 4'h0, 4'h0);
		repeat (10) @(negedge i_clk);
		chk_cnt(n_done, 1);
		rd(4'h5);
		chk_word(q, {D1, D0});
	endtask
	task automatic t_mask();
		u_sram_ctrl_model.burst(1'b0, 4'h5, 36'h555555555, 36'haaaaaaaaa, 4'h5, 4'ha);
		wait_done(2);
		rd(4'h5);
		chk_word(q, {merge(D1, 36'haaaaaaaaa, 4'ha), merge(D0, 36'h555555555, 4'h5)});
	endtask
	task automatic t_full_buf();
		i_array_hold = 1'b1;
		u_sram_ctrl_model.burst(1'b0, 4'h1, D1, D0, 4'h0, 4'h0);
		u_sram_ctrl_model.burst(1'b0, 4'h2, D0, D0, 4'h0, 4'h0);
		repeat (4) @(negedge i_clk);
		chk_bit(o_wr_ready, 1'b0);
		u_sram_ctrl_model.burst(1'b0, 4'h3, D1, D1, 4'h0, 4'h0);
		repeat (6) @(negedge i_clk);
		chk_cnt(n_over, 1);
		i_array_hold = 1'b0;
		wait_done(4);
		rd(4'h1);
		chk_word(q, {D0, D1});
		rd(4'h2);
		chk_word(q, {D0, D0});
	endtask
	task automatic t_reset();
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		chk_bit(o_wr_ready, 1'b0);
		i_sys_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		chk_bit(o_wr_ready, 1'b1);
	endtask
	task automatic t_nibble();
		u_sram_ctrl_model_x8.burst(1'b0, 4'h6, 8'h3c, 8'ha5, 4'h0, 4'h0);
		u_sram_ctrl_model_x8.burst(1'b0, 4'h6, 8'hff, 8'h00, 4'hd, 4'he);
		repeat (4) @(negedge i_clk);
		chk_cnt(n_done8, 2);
		rd(4'h6);
		chk_word((2*DW)'(q8), (2*DW)'(16'ha0fc));
	endtask
	// Main sequence
	initial begin
		repeat (2) @(negedge i_clk);
		i_sys_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		t_full();
		t_desel();
		t_mask();
		t_full_buf();
		t_reset();
		t_nibble();
		results();
	end
	// Cut a hang short
	initial begin
		#100000;
		bad("run timed out");
		results();
	end
endmodule
